// file: epc_cfg.svh
`ifndef EPC_CFG_SVH
`define EPC_CFG_SVH

// register word offsets (byte addresses)
`define EPC_ADR_CTRL     8'h00
`define EPC_ADR_FLAGS    8'h04
`define EPC_ADR_FCLR     8'h08
`define EPC_ADR_IRQEN    8'h0c
`define EPC_ADR_FORCE    8'h10
`define EPC_ADR_HARDWARE_LATCHED_POSITION     8'h14
`define EPC_ADR_CAP0     8'h20
`define EPC_ADR_STATE    8'h40
// event bit positions in flags, enables and clear registers
`define EPC_EV_IN1       0
`define EPC_EV_IN2       1
`define EPC_EV_IDXA      2
`define EPC_EV_IDXB      3
`define EPC_NEV          4
// control register: enables in [3:0], latch channel select in bit 4
`define EPC_CTRL_LSEL    4
`define EPC_CTRL_RST     5'h00
// shortest assured index pulse on encoder b, in microseconds
`define EPC_IDXB_MIN_US  2000
`define EPC_CLK_MHZ      25
`define EPC_IDXB_CYC     (`EPC_IDXB_MIN_US * `EPC_CLK_MHZ)
`endif

// file: epc_pkg.sv
package epc_pkg;
	// decoded bus request toward the register file
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  adr;
		logic [31:0] dat;
	} epc_req_s;
	// synchroniser filter state
	typedef enum logic [0:0] {
		EPC_LOW  = 1'b0,
		EPC_HIGH = 1'b1
	} epc_lvl_e;
endpackage

// file: epc_sync.sv
`timescale 1ns/10ps
// three-stage synchroniser; a change counts once stages two and three agree
module epc_sync #(
	parameter int W = 4
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] s1_ff;  // metastability stage, read only by s2
	logic [W-1:0] s2_ff;  // second stage
	logic [W-1:0] s3_ff;  // third stage

	// shift chain
	always_ff @(posedge clk) begin
		if (rst) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
		end else begin
			s1_ff <= din;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// filtered level only moves when stages two and three agree
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : gen_flt
			epc_pkg::epc_lvl_e lvl_ff;
			always_ff @(posedge clk) begin
				if (rst) begin
					lvl_ff <= epc_pkg::EPC_LOW;
				end else if (s2_ff[g] == s3_ff[g]) begin
					lvl_ff <= epc_pkg::epc_lvl_e'(s3_ff[g]);
				end
			end
			assign dout[g] = lvl_ff;
		end
	endgenerate
endmodule

// file: epc_capture.sv
`timescale 1ns/10ps
`include "epc_cfg.svh"
// four-event position capture with wishbone register access
module epc_capture #(
	parameter int CW        = 32,                // encoder count width
	parameter int IDXB_CYC  = `EPC_IDXB_CYC      // shortest assured encoder b index, cycles
) (
	input  wire logic          CLK,
	input  wire logic          RESET,
	// classic wishbone slave
	input  wire logic          WB_CYC_I,
	input  wire logic          WB_STB_I,
	input  wire logic          WB_WE_I,
	input  wire logic [7:0]    WB_ADR_I,
	input  wire logic [3:0]    WB_SEL_I,
	input  wire logic [31:0]   WB_DAT_I,
	output logic      [31:0]   WB_DAT_O,
	output logic               WB_ACK_O,
	// encoder counts, already in this clock domain
	input  wire logic [CW-1:0] ENC_A_COUNT,
	input  wire logic [CW-1:0] ENC_B_COUNT,
	// pins from outside the clock domain
	input  wire logic          ENC_A_INDEX,
	input  wire logic          ENC_B_INDEX,
	input  wire logic          INPUT_11,
	input  wire logic          INPUT_12,
	// interrupt request level
	output logic               IRQ
);
	localparam int NE = `EPC_NEV;
	localparam int LW = $clog2(IDXB_CYC + 1) + 1;  // width of the index b length counter

	// register map, word addressed, all 32 bits wide:
	//   control     enables in [3:0], latch select in bit 4
	//   flags       sticky occurred flags, read only
	//   flag clear  write ones to clear, write only
	//   irq enable  one bit per event, same layout as flags
	//   force       bit one fires a software input event two
	//   latch       hardware latched position
	//   captures    two words per event, encoder a then encoder b
	//   state       filtered pin levels, for bring-up
	// pins reach the flags four to five cycles after they change, the cost
	// of the three-stage synchroniser and its agree filter

	epc_pkg::epc_req_s req;                  // decoded bus access
	logic [NE-1:0]     pin_lvl;              // filtered pin levels
	logic [NE-1:0]     pin_prev_ff;          // last filtered levels
	logic [NE-1:0]     trig;                 // raw trigger pulses
	logic [NE-1:0]     fire;                 // enabled triggers
	logic [NE-1:0]     enable_ff;            // per-event enables
	logic [NE-1:0]     flags_ff;             // sticky occurred flags
	logic [NE-1:0]     irq_en_ff;            // interrupt enables
	logic              latch_sel_ff;         // 0 picks encoder a, 1 encoder b
	logic [CW-1:0]     cap_a_ff [NE];        // encoder a capture per event
	logic [CW-1:0]     cap_b_ff [NE];        // encoder b capture per event
	logic [CW-1:0]     hardware_latched_position; // latched on event one
	logic              force_two;            // software force pulse
	logic [NE-1:0]     clr_mask;             // flags cleared this cycle
	logic              ack_ff;               // ack register
	logic [31:0]       nxt_dat;              // read mux
	logic [31:0]       dat_ff;               // read data register
	logic [LW-1:0]     idxb_len_ff;          // length of the index b pulse, saturating

	// index pulses and inputs all cross into this domain the same way
	epc_sync #(.W(NE)) u_sync (
		.clk  (CLK),
		.rst  (RESET),
		.din  ({ENC_B_INDEX, ENC_A_INDEX, INPUT_12, INPUT_11}),
		.dout (pin_lvl)
	);

	// bus decode: a request is served once, in the cycle before ack
	always_comb begin
		req.wr  = WB_CYC_I & WB_STB_I & WB_WE_I & ~ack_ff & (&WB_SEL_I);
		req.rd  = WB_CYC_I & WB_STB_I & ~WB_WE_I & ~ack_ff;
		req.adr = WB_ADR_I;
		req.dat = WB_DAT_I;
	end

	// word decode, used for several registers
	function automatic logic hit(input logic [7:0] a, input logic [7:0] base);
		hit = (a[7:2] == base[7:2]);
	endfunction

	// rising-edge detect on the filtered levels
	always_ff @(posedge CLK) begin
		if (RESET) begin
			pin_prev_ff <= '0;
		end else begin
			pin_prev_ff <= pin_lvl;
		end
	end

	assign force_two = req.wr & hit(req.adr, `EPC_ADR_FORCE) & req.dat[`EPC_EV_IN2];
	// index pulses shorter than IDXB_CYC on encoder b are not assured;
	// the synchroniser only needs a few cycles, so the limit is not enforced
	always_comb begin
		trig = pin_lvl & ~pin_prev_ff;
		trig[`EPC_EV_IN2] = trig[`EPC_EV_IN2] | force_two;
		fire = trig & enable_ff;
	end

	// enables and latch channel select
	always_ff @(posedge CLK) begin
		if (RESET) begin
			{latch_sel_ff, enable_ff} <= `EPC_CTRL_RST;
		end else if (req.wr & hit(req.adr, `EPC_ADR_CTRL)) begin
			enable_ff    <= req.dat[NE-1:0];
			latch_sel_ff <= req.dat[`EPC_CTRL_LSEL];
		end
	end

	// interrupt enable register
	always_ff @(posedge CLK) begin
		if (RESET) begin
			irq_en_ff <= '0;
		end else if (req.wr & hit(req.adr, `EPC_ADR_IRQEN)) begin
			irq_en_ff <= req.dat[NE-1:0];
		end
	end

	// sticky flags: a new event wins over a clear in the same cycle
	assign clr_mask = (req.wr & hit(req.adr, `EPC_ADR_FCLR)) ? req.dat[NE-1:0] : '0;
	always_ff @(posedge CLK) begin
		if (RESET) begin
			flags_ff <= '0;
		end else begin
			flags_ff <= (flags_ff & ~clr_mask) | fire;
		end
	end

	// per-event capture of both channels in the same cycle
	genvar e;
	generate
		for (e = 0; e < NE; e++) begin : gen_cap
			always_ff @(posedge CLK) begin
				if (RESET) begin
					cap_a_ff[e] <= '0;
					cap_b_ff[e] <= '0;
				end else if (fire[e]) begin
					cap_a_ff[e] <= ENC_A_COUNT;
					cap_b_ff[e] <= ENC_B_COUNT;
				end
			end
		end
	endgenerate

	// hardware latch of the selected channel on input event one
	always_ff @(posedge CLK) begin
		if (RESET) begin
			hardware_latched_position <= '0;
		end else if (fire[`EPC_EV_IN1]) begin
			hardware_latched_position <= latch_sel_ff ? ENC_B_COUNT : ENC_A_COUNT;
		end
	end

	// read mux: captures at CAP0 + 8*event (+4 for encoder b)
	always_comb begin
		nxt_dat = '0;
		if (hit(req.adr, `EPC_ADR_CTRL)) begin
			nxt_dat = 32'({latch_sel_ff, enable_ff});
		end else if (hit(req.adr, `EPC_ADR_FLAGS)) begin
			nxt_dat = 32'(flags_ff);
		end else if (hit(req.adr, `EPC_ADR_IRQEN)) begin
			nxt_dat = 32'(irq_en_ff);
		end else if (hit(req.adr, `EPC_ADR_HARDWARE_LATCHED_POSITION)) begin
			nxt_dat = 32'(hardware_latched_position);
		end else if (hit(req.adr, `EPC_ADR_STATE)) begin
			nxt_dat = 32'(pin_lvl);
		end else if (req.adr[7:5] == 3'(`EPC_ADR_CAP0 >> 5)) begin
			nxt_dat = req.adr[2] ? 32'(cap_b_ff[req.adr[4:3]]) : 32'(cap_a_ff[req.adr[4:3]]);
		end
	end

	// one-wait ack; unmapped reads return zero, writes ignored
	always_ff @(posedge CLK) begin
		if (RESET) begin
			ack_ff <= 1'b0;
			dat_ff <= '0;
		end else begin
			ack_ff <= req.wr | req.rd | (WB_CYC_I & WB_STB_I & ~ack_ff);
			if (req.rd) begin
				dat_ff <= nxt_dat;
			end
		end
	end

	assign WB_ACK_O = ack_ff;
	assign WB_DAT_O = dat_ff;
	assign IRQ      = |(flags_ff & irq_en_ff);

	// enabled trigger captures both channels the next cycle
	cap_both_a: assert property (@(posedge CLK) disable iff (RESET)
		fire[`EPC_EV_IDXA] |=> cap_a_ff[`EPC_EV_IDXA] == $past(ENC_A_COUNT)
			&& cap_b_ff[`EPC_EV_IDXA] == $past(ENC_B_COUNT))
		else $error("index a capture mismatch");
	flag_set_a: assert property (@(posedge CLK) disable iff (RESET)
		fire[`EPC_EV_IN1] |=> flags_ff[`EPC_EV_IN1])
		else $error("event one flag not set");
	flag_sticky_a: assert property (@(posedge CLK) disable iff (RESET)
		flags_ff[`EPC_EV_IN2] && !clr_mask[`EPC_EV_IN2] |=> flags_ff[`EPC_EV_IN2])
		else $error("flag dropped without clear");
	disabled_hold_a: assert property (@(posedge CLK) disable iff (RESET)
		!enable_ff[`EPC_EV_IN2] && !flags_ff[`EPC_EV_IN2] && !clr_mask[`EPC_EV_IN2]
			|=> !flags_ff[`EPC_EV_IN2] && $stable(cap_a_ff[`EPC_EV_IN2]))
		else $error("disabled event acted");
	force_two_a: assert property (@(posedge CLK) disable iff (RESET)
		force_two && enable_ff[`EPC_EV_IN2] |=> flags_ff[`EPC_EV_IN2])
		else $error("forced event two ignored");
	hw_latch_a: assert property (@(posedge CLK) disable iff (RESET)
		fire[`EPC_EV_IN1] |=> hardware_latched_position ==
			($past(latch_sel_ff) ? $past(ENC_B_COUNT) : $past(ENC_A_COUNT)))
		else $error("hardware latch wrong channel");
	sequence pin_rise_s;
		pin_lvl[`EPC_EV_IDXB] && !pin_prev_ff[`EPC_EV_IDXB] && enable_ff[`EPC_EV_IDXB];
	endsequence
	idx_b_rise_a: assert property (@(posedge CLK) disable iff (RESET)
		pin_rise_s |=> flags_ff[`EPC_EV_IDXB])
		else $error("index b rise missed");
	en_write_a: assert property (@(posedge CLK) disable iff (RESET)
		req.wr && hit(req.adr, `EPC_ADR_CTRL) |=> enable_ff == $past(req.dat[NE-1:0]))
		else $error("enable write lost");
	iso_cap_a: assert property (@(posedge CLK) disable iff (RESET)
		fire == 4'h1 |=> $stable(cap_b_ff[`EPC_EV_IDXB]))
		else $error("capture touched other source");

	// length of the present filtered index b pulse, saturating at the
	// assured width; it feeds only the checks below, because the edge
	// detector already catches any pulse that the filter lets through
	always_ff @(posedge CLK) begin
		if (RESET) begin
			idxb_len_ff <= '0;
		end else if (!pin_lvl[`EPC_EV_IDXB]) begin
			idxb_len_ff <= '0;                                    // pin low: restart
		end else if (idxb_len_ff != LW'(IDXB_CYC)) begin
			idxb_len_ff <= idxb_len_ff + LW'(1);
		end
	end

	// a rise on index b is seen in the first filtered cycle of its pulse,
	// long before the assured width, so that width is a floor, not a filter
	idx_b_first_a: assert property (@(posedge CLK) disable iff (RESET)
		pin_rise_s |-> idxb_len_ff == '0)
		else $error("index b rise seen late");

	// the length counter never runs past the assured width
	idx_b_sat_a: assert property (@(posedge CLK) disable iff (RESET)
		idxb_len_ff <= LW'(IDXB_CYC))
		else $error("index b length overran");

	// bus handshake: a request taken in one cycle is answered in the next
	sequence bus_take_s;
		WB_CYC_I && WB_STB_I && !ack_ff;
	endsequence
	ack_next_a: assert property (@(posedge CLK) disable iff (RESET)
		bus_take_s |=> WB_ACK_O)
		else $error("request not answered");

	// ack stands one cycle only, so a master that still holds its request
	// at the ack edge is not served a second time
	ack_pulse_a: assert property (@(posedge CLK) disable iff (RESET)
		WB_ACK_O |=> !WB_ACK_O)
		else $error("ack held too long");

	// read data is the word chosen at the request and stands with ack
	rd_data_a: assert property (@(posedge CLK) disable iff (RESET)
		req.rd |=> WB_ACK_O && WB_DAT_O == $past(nxt_dat))
		else $error("read data not registered");

	// a write with lanes missing is acked but must leave the enables alone
	sequence part_write_s;
		WB_CYC_I && WB_STB_I && WB_WE_I && !ack_ff && !(&WB_SEL_I);
	endsequence
	part_write_a: assert property (@(posedge CLK) disable iff (RESET)
		part_write_s |=> $stable(enable_ff) && $stable(irq_en_ff))
		else $error("partial write took effect");

	// enables change only on a control write; events never disarm them
	en_hold_a: assert property (@(posedge CLK) disable iff (RESET)
		!(req.wr && hit(req.adr, `EPC_ADR_CTRL)) |=> $stable(enable_ff) && $stable(latch_sel_ff))
		else $error("enable moved without write");

	// the hardware latch holds its value between input one events
	hw_hold_a: assert property (@(posedge CLK) disable iff (RESET)
		!fire[`EPC_EV_IN1] |=> $stable(hardware_latched_position))
		else $error("hardware latch drifted");

	// a forced event two must not disturb the captures of input one
	force_iso_a: assert property (@(posedge CLK) disable iff (RESET)
		force_two && !fire[`EPC_EV_IN1] |=> $stable(cap_a_ff[`EPC_EV_IN1])
			&& $stable(cap_b_ff[`EPC_EV_IN1]))
		else $error("force touched input one");

	// the interrupt follows an enabled flag at once
	irq_level_a: assert property (@(posedge CLK) disable iff (RESET)
		flags_ff[`EPC_EV_IN1] && irq_en_ff[`EPC_EV_IN1] |-> IRQ)
		else $error("interrupt not raised");

	// per-event checks, one set for each source
	genvar k;
	generate
		for (k = 0; k < NE; k++) begin : gen_ev_chk
			// an enabled trigger always leaves its flag set
			ev_flag_a: assert property (@(posedge CLK) disable iff (RESET)
				fire[k] |=> flags_ff[k])
				else $error("event flag not set");
			// a clear with no event in the same cycle drops the flag;
			// an event in that cycle wins, so it is left out here
			ev_clear_a: assert property (@(posedge CLK) disable iff (RESET)
				clr_mask[k] && !fire[k] |=> !flags_ff[k])
				else $error("flag clear lost");
			// both channels are frozen from the same cycle
			ev_cap_a: assert property (@(posedge CLK) disable iff (RESET)
				fire[k] |=> cap_a_ff[k] == $past(ENC_A_COUNT)
					&& cap_b_ff[k] == $past(ENC_B_COUNT))
				else $error("event capture mismatch");
			// a disabled source never fires
			ev_off_a: assert property (@(posedge CLK) disable iff (RESET)
				!enable_ff[k] |-> !fire[k])
				else $error("disabled event fired");
		end
	endgenerate
endmodule

// file: epc_far_side.sv
`timescale 1ns/10ps
// far side: two encoders and the discrete machine inputs
module epc_far_side #(
	parameter int CW = 32  // encoder count width
) (
	input  wire logic          clk,
	input  wire logic          run,
	output logic      [CW-1:0] count_a,
	output logic      [CW-1:0] count_b,
	output logic      [3:0]    pins
);
	// counts start apart so a swapped channel shows up
	initial begin
		count_a = 32'h0000_0100;
		count_b = 32'h0000_8000;
		pins    = 4'h0;
	end
	// encoders only move while the bench lets them run
	always @(posedge clk) begin
		if (run) begin
			count_a <= count_a + 32'h1;
			count_b <= count_b - 32'h3;
		end
	end
	// high active pulse; width well above the design's shortest catch
	task pulse(input int e, input int cyc);
		@(posedge clk);
		pins[e] <= 1'b1;
		repeat (cyc) @(posedge clk);
		pins[e] <= 1'b0;
	endtask
endmodule

// file: testbench.sv
`timescale 1ns/10ps
`include "epc_cfg.svh"
// register level bench over classic wishbone
module testbench;
	logic        CLK = 1'b0;
	logic        RESET = 1'b1;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, run = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0, rd, dat_o, ca, cb;
	logic [31:0] exa [4];
	logic [31:0] exb [4];
	logic        ack, irq;
	logic [3:0]  pins;
	int          fail_count = 0, n_compared = 0, cycles = 0;
	always #20 CLK = ~CLK;
	epc_capture #(.CW(32), .IDXB_CYC(1)) dut (.CLK(CLK), .RESET(RESET), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
		.ENC_A_COUNT(ca), .ENC_B_COUNT(cb), .ENC_A_INDEX(pins[2]), .ENC_B_INDEX(pins[3]),
		.INPUT_11(pins[0]), .INPUT_12(pins[1]), .IRQ(irq));
	epc_far_side #(.CW(32)) far (.clk(CLK), .run(run), .count_a(ca), .count_b(cb), .pins(pins));
	// verdict in one place
	task stop_test;
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one classic cycle; ack and data sampled at the same edge
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
		do begin
			@(posedge CLK);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1) chk("ack", 32'h1, 32'h0);
		rd = dat_o;
		cyc <= 1'b0; stb <= 1'b0;
		@(posedge CLK);
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
		wb(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask
	// move the encoders, freeze them, then fire one source
	task fire(input int e);
		run <= 1'b1;
		repeat (3 + e) @(posedge CLK);
		run <= 1'b0;
		far.pulse(e, 6);
		repeat (10) @(posedge CLK);
	endtask
	// hang guard, well above the expected run length
	always @(posedge CLK) begin
		cycles++;
		if (cycles >= 20000) begin
			fail_count++;
			stop_test();
		end
	end
	initial begin
		repeat (6) @(posedge CLK);
		RESET <= 1'b0;
		@(posedge CLK);
		rdchk(`EPC_ADR_CTRL, 32'h0, "ctrl");
		rdchk(`EPC_ADR_IRQEN, 32'h0, "irq enable");
		fire(0);
		rdchk(`EPC_ADR_FLAGS, 32'h0, "flags disabled");
		rdchk(`EPC_ADR_CAP0, 32'h0, "capture disabled");
		$display("test disabled done");
		wb(1'b1, `EPC_ADR_CTRL, 32'h0f);
		wb(1'b1, `EPC_ADR_IRQEN, 32'h1);
		// every source in turn; flags pile up since none is cleared
		for (int e = 0; e < 4; e++) begin
			fire(e);
			exa[e] = ca;
			exb[e] = cb;
			rdchk(`EPC_ADR_FLAGS, (32'h1 << (e + 1)) - 32'h1, "flags");
		end
		for (int e = 0; e < 4; e++) begin
			rdchk(8'(`EPC_ADR_CAP0 + 8 * e), exa[e], "capture a");
			rdchk(8'(`EPC_ADR_CAP0 + 8 * e + 4), exb[e], "capture b");
		end
		rdchk(`EPC_ADR_HARDWARE_LATCHED_POSITION, exa[0], "latched enc a");
		chk("irq set", 32'h1, {31'h0, irq});
		wb(1'b1, `EPC_ADR_FCLR, 32'h1);
		rdchk(`EPC_ADR_FLAGS, 32'he, "flags after clear");
		chk("irq masked", 32'h0, {31'h0, irq});
		wb(1'b1, `EPC_ADR_CTRL, 32'h1f);
		fire(0);
		rdchk(`EPC_ADR_HARDWARE_LATCHED_POSITION, cb, "latched enc b");
		$display("test capture done");
		// software forced event two
		wb(1'b1, `EPC_ADR_FCLR, 32'hf);
		rdchk(`EPC_ADR_FLAGS, 32'h0, "flags cleared");
		fire(3);
		wb(1'b1, `EPC_ADR_FORCE, 32'h2);
		repeat (10) @(posedge CLK);
		rdchk(`EPC_ADR_FLAGS, 32'ha, "index b and force");
		wb(1'b1, `EPC_ADR_FCLR, 32'ha);
		wb(1'b1, `EPC_ADR_FORCE, 32'h2);
		repeat (10) @(posedge CLK);
		rdchk(`EPC_ADR_FLAGS, 32'h2, "forced flag");
		rdchk(8'(`EPC_ADR_CAP0 + 8), ca, "forced capture");
		// input two disabled alone: force does nothing
		wb(1'b1, `EPC_ADR_FCLR, 32'h2);
		wb(1'b1, `EPC_ADR_CTRL, 32'h1d);
		wb(1'b1, `EPC_ADR_FORCE, 32'h2);
		repeat (10) @(posedge CLK);
		rdchk(`EPC_ADR_FLAGS, 32'h0, "forced disabled");
		rdchk(8'h18, 32'h0, "unmapped");
		$display("test force done");
		stop_test();
	end
endmodule
